// ---- rtl/func_select_out.sv ----
`timescale 1ns/10ps
module func_select_out (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] code,
  input wire logic [18:0] cond,
  output logic out_r
);
  // ****************************************
  // code to condition select
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else if (code < ots_pkg::FUNC_LIMIT) begin
      out_r <= cond[code];
    end else begin
      out_r <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_code_zero;
    @(posedge clk) disable iff (!rst_n) code == ots_pkg::FN_NONE |=> !out_r;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("code 0 output not inactive");

  property p_follow;
    @(posedge clk) disable iff (!rst_n)
      code < ots_pkg::FUNC_LIMIT |=> out_r == $past(cond[code]);
  endproperty
  a_follow: assert property (p_follow) else $error("output not following condition");

  property p_undef;
    @(posedge clk) disable iff (!rst_n) code >= ots_pkg::FUNC_LIMIT |=> !out_r;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code drives output");
endmodule

// ---- rtl/ots_pkg.sv ----
package ots_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SEL_BASE = 8'h04;
  localparam logic [7:0] ADR_SET_CNT = 8'h18;
  localparam logic [7:0] ADR_DESIG_CNT = 8'h1C;
  localparam logic [7:0] ADR_LEN_SP = 8'h20;
  localparam logic [7:0] ADR_RUNTIME = 8'h24;
  localparam logic [7:0] ADR_PULSE_PER = 8'h28;
  localparam logic [7:0] ADR_STATUS = 8'h2C;
  localparam int CTRL_MODE_BIT = 0;
  localparam int STAT_FM_BIT = 5;
  localparam int STAT_MODE_BIT = 6;
  localparam int STAT_PULSE_BIT = 7;
  // ****************************************
  // outputs and function codes
  // ****************************************
  localparam int NUM_OUT = 5;
  localparam int FUNC_W = 5;
  localparam int NUM_FUNC = 19;
  localparam logic [4:0] FUNC_LIMIT = 5'h13;
  localparam int OUT_SWITCH = 0;
  localparam int OUT_MAIN_RELAY = 1;
  localparam int OUT_EXT_RELAY = 2;
  localparam int OUT_OC_ONE = 3;
  localparam int OUT_EXT_TWO = 4;
  localparam logic [4:0] FN_NONE = 5'h00;
  localparam logic [4:0] FN_RUNNING = 5'h01;
  localparam logic [4:0] FN_FAULT_STOP = 5'h02;
  localparam logic [4:0] FN_FREQ_LEVEL = 5'h03;
  localparam logic [4:0] FN_FREQ_REACHED = 5'h04;
  localparam logic [4:0] FN_ZERO_SPEED = 5'h05;
  localparam logic [4:0] FN_MOTOR_OL = 5'h06;
  localparam logic [4:0] FN_DRIVE_OL = 5'h07;
  localparam logic [4:0] FN_SET_COUNT = 5'h08;
  localparam logic [4:0] FN_DESIG_COUNT = 5'h09;
  localparam logic [4:0] FN_LENGTH = 5'h0A;
  localparam logic [4:0] FN_SEQ_DONE = 5'h0B;
  localparam logic [4:0] FN_RUN_TIME = 5'h0C;
  localparam logic [4:0] FN_FREQ_LIMITED = 5'h0D;
  localparam logic [4:0] FN_TORQUE_LIMIT = 5'h0E;
  localparam logic [4:0] FN_READY = 5'h0F;
  localparam logic [4:0] FN_AI_COMPARE = 5'h10;
  localparam logic [4:0] FN_UPPER_LIMIT = 5'h11;
  localparam logic [4:0] FN_LOWER_LIMIT = 5'h12;
  localparam logic [4:0] SEL_RST [0:4] = '{5'h00, 5'h02, 5'h00, 5'h01, 5'h04};
  localparam logic MODE_PULSE = 1'b0;
  localparam logic MODE_SWITCH = 1'b1;
  localparam logic MODE_RST = MODE_PULSE;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int PULSE_MAX_HZ = 50_000;
  localparam int PERIOD_W = 16;
  localparam logic [15:0] PULSE_MIN_PERIOD = 16'((CLK_HZ + PULSE_MAX_HZ - 1) / PULSE_MAX_HZ);
  localparam logic [15:0] PULSE_PER_RST = 16'h0000;
  localparam int SEQ_PULSE_MS = 250;
  localparam int SEQ_PULSE_CYCLES = (CLK_HZ / 1000) * SEQ_PULSE_MS;
  localparam int STRETCH_W = 24;
  localparam int OL_LEAD_S = 10;
  localparam logic [31:0] OL_LEAD_MS = 32'(OL_LEAD_S * 1000);
endpackage

// ---- rtl/output_terminal_function_select.sv ----
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module output_terminal_function_select #(
  parameter int SEQ_PULSE_LEN = ots_pkg::SEQ_PULSE_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic RUN_ACTIVE,
  input wire logic FAULT_STOP,
  input wire logic FAULT_PRESENT,
  input wire logic FREQ_LEVEL_DETECT_ONE,
  input wire logic FREQ_REACHED,
  input wire logic ZERO_FREQ,
  input wire logic MOTOR_OL_PREWARN,
  input wire logic OL_TRIP_PENDING,
  input wire logic [31:0] OL_TRIP_MS,
  input wire logic [31:0] COUNT_VALUE,
  input wire logic [31:0] ACTUAL_LENGTH,
  input wire logic [31:0] RUN_TIME,
  input wire logic SEQ_CYCLE_DONE,
  input wire logic SET_ABOVE_UPPER,
  input wire logic SET_BELOW_LOWER,
  input wire logic AT_UPPER_LIMIT,
  input wire logic AT_LOWER_LIMIT,
  input wire logic SPEED_MODE,
  input wire logic TORQUE_AT_LIMIT,
  input wire logic STALL_ACTIVE,
  input wire logic MAIN_STABLE,
  input wire logic CTRL_STABLE,
  input wire logic [11:0] ANALOG_INPUT_ONE,
  input wire logic [11:0] ANALOG_INPUT_TWO,
  output logic FM_OUT,
  output logic MAIN_RELAY,
  output logic EXT_RELAY,
  output logic OPEN_COLLECTOR_OUT_ONE,
  output logic EXTENSION_OUT_TWO
);
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rd_nxt;
  logic wb_hit;
  logic wr_en;
  logic [7:0] adr;
  logic mode_r;
  logic [4:0] sel_r [0:4];
  logic [31:0] set_cnt_r;
  logic [31:0] desig_cnt_r;
  logic [31:0] len_sp_r;
  logic [31:0] runtime_r;
  logic [15:0] period_r;
  logic [23:0] stretch_r;
  logic [18:0] cond;
  logic [4:0] sw_out;
  logic pulse_w;
  logic fm_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // wishbone slave
  // ****************************************
  assign wb_hit = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr_en = wb_hit & WB_WE_I;
  assign adr = {WB_ADR_I[7:2], 2'b00};

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_hit;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (adr)
      ots_pkg::ADR_CTRL: rd_nxt[ots_pkg::CTRL_MODE_BIT] = mode_r;
      ots_pkg::ADR_SET_CNT: rd_nxt = set_cnt_r;
      ots_pkg::ADR_DESIG_CNT: rd_nxt = desig_cnt_r;
      ots_pkg::ADR_LEN_SP: rd_nxt = len_sp_r;
      ots_pkg::ADR_RUNTIME: rd_nxt = runtime_r;
      ots_pkg::ADR_PULSE_PER: rd_nxt[15:0] = period_r;
      ots_pkg::ADR_STATUS: begin
        rd_nxt[4:0] = sw_out;
        rd_nxt[ots_pkg::STAT_FM_BIT] = fm_r;
        rd_nxt[ots_pkg::STAT_MODE_BIT] = mode_r;
        rd_nxt[ots_pkg::STAT_PULSE_BIT] = pulse_w;
      end
      default: begin
        for (int i = 0; i < ots_pkg::NUM_OUT; i++) begin
          if (adr == ots_pkg::ADR_SEL_BASE + 8'(4 * i)) begin
            rd_nxt[4:0] = sel_r[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      rdat_r <= 32'h0000_0000;
    end else if (wb_hit && !WB_WE_I) begin
      rdat_r <= rd_nxt;
    end
  end

  assign WB_DAT_O = rdat_r;
  assign WB_ACK_O = ack_r;

  // ****************************************
  // mode and selector registers
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      mode_r <= ots_pkg::MODE_RST;
    end else if (wr_en && adr == ots_pkg::ADR_CTRL && WB_SEL_I[0]) begin
      mode_r <= WB_DAT_I[ots_pkg::CTRL_MODE_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    for (int i = 0; i < ots_pkg::NUM_OUT; i++) begin
      if (!RSTN) begin
        sel_r[i] <= ots_pkg::SEL_RST[i];
      end else if (wr_en && WB_SEL_I[0] && adr == ots_pkg::ADR_SEL_BASE + 8'(4 * i)) begin
        sel_r[i] <= WB_DAT_I[4:0];
      end
    end
  end

  // ****************************************
  // threshold and period registers
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      set_cnt_r <= 32'h0000_0000;
      desig_cnt_r <= 32'h0000_0000;
      len_sp_r <= 32'h0000_0000;
      runtime_r <= 32'h0000_0000;
      period_r <= ots_pkg::PULSE_PER_RST;
    end else if (wr_en) begin
      if (adr == ots_pkg::ADR_SET_CNT) set_cnt_r <= merge(set_cnt_r, WB_DAT_I, WB_SEL_I);
      if (adr == ots_pkg::ADR_DESIG_CNT) desig_cnt_r <= merge(desig_cnt_r, WB_DAT_I, WB_SEL_I);
      if (adr == ots_pkg::ADR_LEN_SP) len_sp_r <= merge(len_sp_r, WB_DAT_I, WB_SEL_I);
      if (adr == ots_pkg::ADR_RUNTIME) runtime_r <= merge(runtime_r, WB_DAT_I, WB_SEL_I);
      if (adr == ots_pkg::ADR_PULSE_PER) begin
        period_r <= 16'(merge({16'h0000, period_r}, WB_DAT_I, WB_SEL_I));
      end
    end
  end

  // ****************************************
  // sequencer cycle pulse stretcher
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      stretch_r <= 24'h000000;
    end else if (SEQ_CYCLE_DONE) begin
      stretch_r <= 24'(SEQ_PULSE_LEN);
    end else if (stretch_r != 24'h000000) begin
      stretch_r <= stretch_r - 24'h000001;
    end
  end

  // ****************************************
  // status conditions
  // ****************************************
  always_comb begin
    cond = 19'h00000;
    cond[ots_pkg::FN_NONE] = 1'b0;
    cond[ots_pkg::FN_RUNNING] = RUN_ACTIVE;
    cond[ots_pkg::FN_FAULT_STOP] = FAULT_STOP;
    cond[ots_pkg::FN_FREQ_LEVEL] = FREQ_LEVEL_DETECT_ONE;
    cond[ots_pkg::FN_FREQ_REACHED] = FREQ_REACHED;
    cond[ots_pkg::FN_ZERO_SPEED] = RUN_ACTIVE & ZERO_FREQ;
    cond[ots_pkg::FN_MOTOR_OL] = MOTOR_OL_PREWARN;
    cond[ots_pkg::FN_DRIVE_OL] = OL_TRIP_PENDING & (OL_TRIP_MS <= ots_pkg::OL_LEAD_MS);
    cond[ots_pkg::FN_SET_COUNT] = COUNT_VALUE >= set_cnt_r;
    cond[ots_pkg::FN_DESIG_COUNT] = COUNT_VALUE >= desig_cnt_r;
    cond[ots_pkg::FN_LENGTH] = ACTUAL_LENGTH > len_sp_r;
    cond[ots_pkg::FN_SEQ_DONE] = stretch_r != 24'h000000;
    cond[ots_pkg::FN_RUN_TIME] = RUN_TIME > runtime_r;
    cond[ots_pkg::FN_FREQ_LIMITED] = (SET_ABOVE_UPPER & AT_UPPER_LIMIT)
                                   | (SET_BELOW_LOWER & AT_LOWER_LIMIT);
    cond[ots_pkg::FN_TORQUE_LIMIT] = SPEED_MODE & TORQUE_AT_LIMIT & STALL_ACTIVE;
    cond[ots_pkg::FN_READY] = MAIN_STABLE & CTRL_STABLE & ~FAULT_PRESENT;
    cond[ots_pkg::FN_AI_COMPARE] = ANALOG_INPUT_ONE > ANALOG_INPUT_TWO;
    cond[ots_pkg::FN_UPPER_LIMIT] = AT_UPPER_LIMIT;
    cond[ots_pkg::FN_LOWER_LIMIT] = RUN_ACTIVE & AT_LOWER_LIMIT;
  end

  // ****************************************
  // output selectors and pulse generator
  // ****************************************
  for (genvar g = 0; g < ots_pkg::NUM_OUT; g++) begin : g_out
    func_select_out u_sel (
      .clk(CLOCK),
      .rst_n(RSTN),
      .code(sel_r[g]),
      .cond(cond),
      .out_r(sw_out[g])
    );
  end

  pulse_train_gen u_pulse (
    .clk(CLOCK),
    .rst_n(RSTN),
    .period(period_r),
    .pulse_r(pulse_w)
  );

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      fm_r <= 1'b0;
    end else begin
      fm_r <= (mode_r == ots_pkg::MODE_SWITCH) ? sw_out[ots_pkg::OUT_SWITCH] : pulse_w;
    end
  end

  assign FM_OUT = fm_r;
  assign MAIN_RELAY = sw_out[ots_pkg::OUT_MAIN_RELAY];
  assign EXT_RELAY = sw_out[ots_pkg::OUT_EXT_RELAY];
  assign OPEN_COLLECTOR_OUT_ONE = sw_out[ots_pkg::OUT_OC_ONE];
  assign EXTENSION_OUT_TWO = sw_out[ots_pkg::OUT_EXT_TWO];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  property p_fm_switch;
    mode_r == ots_pkg::MODE_SWITCH |=> FM_OUT == $past(sw_out[ots_pkg::OUT_SWITCH]);
  endproperty
  a_fm_switch: assert property (p_fm_switch) else $error("switch mode not on terminal");

  property p_fm_pulse;
    mode_r == ots_pkg::MODE_PULSE |=> FM_OUT == $past(pulse_w);
  endproperty
  a_fm_pulse: assert property (p_fm_pulse) else $error("pulse mode not on terminal");

  property p_reset_vals;
    $rose(RSTN) |-> mode_r == ots_pkg::MODE_RST && sel_r[0] == 5'h00 && sel_r[1] == 5'h02
                    && sel_r[2] == 5'h00 && sel_r[3] == 5'h01 && sel_r[4] == 5'h04;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset selector values");

  property p_run;
    sel_r[1] == ots_pkg::FN_RUNNING |=> MAIN_RELAY == $past(RUN_ACTIVE);
  endproperty
  a_run: assert property (p_run) else $error("relay not following run");

  property p_zero_stop;
    sel_r[3] == ots_pkg::FN_ZERO_SPEED && !RUN_ACTIVE |=> !OPEN_COLLECTOR_OUT_ONE;
  endproperty
  a_zero_stop: assert property (p_zero_stop) else $error("zero speed on while stopped");

  property p_lower_stop;
    sel_r[4] == ots_pkg::FN_LOWER_LIMIT && !RUN_ACTIVE |=> !EXTENSION_OUT_TWO;
  endproperty
  a_lower_stop: assert property (p_lower_stop) else $error("lower limit on while stopped");

  property p_drive_ol;
    sel_r[1] == ots_pkg::FN_DRIVE_OL && OL_TRIP_PENDING && OL_TRIP_MS <= ots_pkg::OL_LEAD_MS
      |=> MAIN_RELAY;
  endproperty
  a_drive_ol: assert property (p_drive_ol) else $error("overload lead warning missing");

  property p_seq_load;
    SEQ_CYCLE_DONE |=> stretch_r == 24'(SEQ_PULSE_LEN);
  endproperty
  a_seq_load: assert property (p_seq_load) else $error("sequencer pulse not started");

  property p_seq_count;
    stretch_r != 24'h000000 && !SEQ_CYCLE_DONE |=> stretch_r == $past(stretch_r) - 24'h000001;
  endproperty
  a_seq_count: assert property (p_seq_count) else $error("sequencer pulse width wrong");

  property p_ack;
    wb_hit |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one cycle");

  property p_cv_mode;
    wr_en && adr == ots_pkg::ADR_CTRL ##1 mode_r == ots_pkg::MODE_SWITCH;
  endproperty
  c_mode: cover property (p_cv_mode);

  property p_cv_seq;
    SEQ_CYCLE_DONE ##1 stretch_r != 24'h000000;
  endproperty
  c_seq: cover property (p_cv_seq);

  property p_cv_relay;
    $rose(MAIN_RELAY);
  endproperty
  c_relay: cover property (p_cv_relay);
endmodule

// ---- rtl/pulse_train_gen.sv ----
`timescale 1ns/10ps
module pulse_train_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] period,
  output logic pulse_r
);
  logic [15:0] eff;
  logic [15:0] cnt_r;
  logic pulse_d_r;
  logic seen_r;
  logic [15:0] gap_r;

  // ****************************************
  // period clamp and divider
  // ****************************************
  assign eff = (period < ots_pkg::PULSE_MIN_PERIOD) ? ots_pkg::PULSE_MIN_PERIOD : period;

  always_ff @(posedge clk) begin
    if (!rst_n || period == 16'h0000) begin
      cnt_r <= 16'h0000;
      pulse_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r >= eff - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
      pulse_r <= (cnt_r < (eff >> 1));
    end
  end

  // ****************************************
  // checks
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_d_r <= 1'b0;
      seen_r <= 1'b0;
      gap_r <= 16'h0000;
    end else begin
      pulse_d_r <= pulse_r;
      if (pulse_r && !pulse_d_r) begin
        seen_r <= 1'b1;
        gap_r <= 16'h0001;
      end else if (gap_r != 16'hFFFF) begin
        gap_r <= gap_r + 16'h0001;
      end
    end
  end

  property p_min_period;
    @(posedge clk) disable iff (!rst_n)
      (pulse_r && !pulse_d_r && seen_r) |-> gap_r >= ots_pkg::PULSE_MIN_PERIOD;
  endproperty
  a_min_period: assert property (p_min_period) else $error("pulse rate above limit");
endmodule

// ---- test/pulse_meter.sv ----
`timescale 1ns/10ps
// ****************************************
// load on the multiplexed terminal: measures pulse timing
// ****************************************
module pulse_meter (
  input wire logic clk,
  input wire logic sig,
  output int high_len,
  output int period
);
  int hi_cnt = 0;
  int per_cnt = 0;
  logic sig_d = 1'b0;
  always @(posedge clk) begin
    sig_d <= sig;
    per_cnt <= per_cnt + 1;
    if (sig) begin
      hi_cnt <= hi_cnt + 1;
    end
    if (sig && !sig_d) begin
      period <= per_cnt;
      per_cnt <= 1;
      hi_cnt <= 1;
    end
    if (!sig && sig_d) begin
      high_len <= hi_cnt;
    end
  end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  localparam int LEN = 20;
  localparam int LIMIT = 12000;
  localparam logic [7:0] SEL_MAIN = 8'h08;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [17:0] s = 18'h0;
  logic [31:0] olms = 32'h0;
  logic [31:0] cnt = 32'h0;
  logic [31:0] len = 32'h0;
  logic [31:0] rt = 32'h0;
  logic [11:0] ai1 = 12'h000;
  logic [11:0] ai2 = 12'h000;
  logic fm, mrel, xrel, oc1, ext2;
  logic [31:0] q;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int hi, per, n;
  // ****************************************
  // design and load
  // ****************************************
  output_terminal_function_select #(.SEQ_PULSE_LEN(LEN)) output_terminal_function_select_i (
    .CLOCK(clock), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .RUN_ACTIVE(s[0]), .FAULT_STOP(s[1]), .FAULT_PRESENT(s[2]),
    .FREQ_LEVEL_DETECT_ONE(s[3]), .FREQ_REACHED(s[4]), .ZERO_FREQ(s[5]),
    .MOTOR_OL_PREWARN(s[6]), .OL_TRIP_PENDING(s[7]), .OL_TRIP_MS(olms),
    .COUNT_VALUE(cnt), .ACTUAL_LENGTH(len), .RUN_TIME(rt), .SEQ_CYCLE_DONE(s[8]),
    .SET_ABOVE_UPPER(s[9]), .SET_BELOW_LOWER(s[10]), .AT_UPPER_LIMIT(s[11]),
    .AT_LOWER_LIMIT(s[12]), .SPEED_MODE(s[13]), .TORQUE_AT_LIMIT(s[14]),
    .STALL_ACTIVE(s[15]), .MAIN_STABLE(s[16]), .CTRL_STABLE(s[17]),
    .ANALOG_INPUT_ONE(ai1), .ANALOG_INPUT_TWO(ai2), .FM_OUT(fm), .MAIN_RELAY(mrel),
    .EXT_RELAY(xrel), .OPEN_COLLECTOR_OUT_ONE(oc1), .EXTENSION_OUT_TWO(ext2));
  pulse_meter pulse_meter_i (.clk(clock), .sig(fm), .high_len(hi), .period(per));
  initial begin
    forever #10 clock = ~clock;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= be;
    dat <= d;
    @(posedge clock);
    while (ack !== 1'b1) @(posedge clock);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hF, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 4'hF, 32'h0);
    chk(q, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  // status inputs that make code c on or off; 99 sets every condition but sequencer done (11) and ready (15)
  task automatic setc(input int c, input bit on);
    logic [17:0] v;
    logic [31:0] ms, cv, lv, rv;
    logic [11:0] a1, a2;
    v = 18'h0;
    ms = 32'hFFFFFFFF;
    cv = 32'h0;
    lv = 32'h0;
    rv = 32'h0;
    a1 = 12'h000;
    a2 = 12'h000;
    case (c)
      1: v[0] = on;
      2: v[1] = on;
      3: v[3] = on;
      4: v[4] = on;
      5: begin v[0] = 1'b1; v[5] = on; end
      6: v[6] = on;
      7: begin v[7] = 1'b1; ms = on ? 32'h2710 : 32'h2711; end
      8: cv = on ? 32'h64 : 32'h63;
      9: cv = on ? 32'hC8 : 32'hC7;
      10: lv = on ? 32'h33 : 32'h32;
      12: rv = on ? 32'h1F : 32'h1E;
      13: begin v[9] = 1'b1; v[11] = on; end
      14: begin v[13] = 1'b1; v[14] = 1'b1; v[15] = on; end
      15: begin v[16] = 1'b1; v[17] = 1'b1; v[2] = !on; end
      16: begin a1 = on ? 12'h801 : 12'h800; a2 = 12'h800; end
      17: v[11] = on;
      18: begin v[0] = 1'b1; v[12] = on; end
      98: begin v[5] = 1'b1; v[12] = 1'b1; end
      99: begin v = 18'h3FEFF; ms = 32'h0; cv = 32'hFFFFFFFF; lv = cv; rv = cv; a1 = 12'hFFF; end
      default: ;
    endcase
    @(posedge clock);
    s <= v;
    olms <= ms;
    cnt <= cv;
    len <= lv;
    rt <= rv;
    ai1 <= a1;
    ai2 <= a2;
  endtask
  // ****************************************
  // timeout
  // ****************************************
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(ots_pkg::ADR_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(ots_pkg::ADR_SEL_BASE + 8'(4 * i), 32'(ots_pkg::SEL_RST[i]));
    end
    rd(ots_pkg::ADR_SET_CNT, 32'h0);
    rd(8'h30, 32'h0);
    wb(1'b1, SEL_MAIN, 4'hE, 32'h1F);
    rd(SEL_MAIN, 32'h2);
    wr(ots_pkg::ADR_SET_CNT, 32'h64);
    wr(ots_pkg::ADR_DESIG_CNT, 32'hC8);
    wr(ots_pkg::ADR_LEN_SP, 32'h32);
    wr(ots_pkg::ADR_RUNTIME, 32'h1E);
    rd(ots_pkg::ADR_SET_CNT, 32'h64);
    for (int c = 0; c < 19; c++) begin
      if (c != 11) begin
        wr(SEL_MAIN, 32'(c));
        setc(c, 1'b1);
        settle();
        chk(mrel, c != 0);
        setc(c, 1'b0);
        settle();
        chk(mrel, 1'b0);
      end
    end
    setc(98, 1'b1);
    wr(SEL_MAIN, 32'h5);
    settle();
    chk(mrel, 1'b0);
    wr(SEL_MAIN, 32'h12);
    settle();
    chk(mrel, 1'b0);
    setc(99, 1'b1);
    wr(SEL_MAIN, 32'h13);
    #1;
    chk(mrel, 1'b0);
    wr(SEL_MAIN, 32'h1);
    #1;
    chk(mrel, 1'b1);
    wr(SEL_MAIN, 32'h1F);
    settle();
    chk(mrel, 1'b0);
    wr(SEL_MAIN, 32'h0);
    settle();
    chk(mrel, 1'b0);
    wr(SEL_MAIN, 32'hB);
    setc(0, 1'b0);
    @(posedge clock);
    s <= 18'h00100;
    @(posedge clock);
    s <= 18'h0;
    n = 0;
    for (int k = 0; k < 60; k++) begin
      @(posedge clock);
      #1;
      if (mrel === 1'b1) n++;
    end
    chk(n, LEN);
    setc(1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(ots_pkg::ADR_SEL_BASE + 8'(4 * i), 32'h1);
    end
    settle();
    chk(fm, 1'b0);
    wr(ots_pkg::ADR_CTRL, 32'h1);
    settle();
    chk({fm, mrel, xrel, oc1, ext2}, 5'h1F);
    wb(1'b0, ots_pkg::ADR_STATUS, 4'hF, 32'h0);
    chk(q, 32'h0000_007F);
    setc(1, 1'b0);
    settle();
    chk({fm, mrel, xrel, oc1, ext2}, 5'h00);
    wr(ots_pkg::ADR_CTRL, 32'h0);
    wr(ots_pkg::ADR_PULSE_PER, 32'h64);
    repeat (2600) @(posedge clock);
    chk(per, ots_pkg::PULSE_MIN_PERIOD);
    chk(hi, ots_pkg::PULSE_MIN_PERIOD / 2);
    chk(32'(ots_pkg::SEQ_PULSE_CYCLES), 32'h00BE_BC20);
    wr(ots_pkg::ADR_CTRL, 32'h1);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(ots_pkg::ADR_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(ots_pkg::ADR_SEL_BASE + 8'(4 * i), 32'(ots_pkg::SEL_RST[i]));
    end
    wrap_up();
  end
endmodule
